// ==== rtl/adc_mode_consts.vh ====
`ifndef ADC_MODE_CONSTS_VH
`define ADC_MODE_CONSTS_VH

// ----------------------------------------------------------------
// Configuration word layout
// ----------------------------------------------------------------
`define CFG_WIDTH 24
`define CFG_MODE_HI 23
`define CFG_MODE_LO 21
`define CFG_GAIN_HI 20
`define CFG_GAIN_LO 18
`define CFG_CHAN 17
`define CFG_PDOWN 16
`define CFG_WLEN 15
`define CFG_EXC 14
`define CFG_BURN 13
`define CFG_POL 12
`define CFG_FILT_HI 11
`define CFG_FILT_LO 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFG_RESET 24'h000000
`define RESULT_RESET 24'h000000

// ----------------------------------------------------------------
// Operating mode codes
// ----------------------------------------------------------------
`define MODE_NORMAL 3'h0
`define MODE_SELF_CAL 3'h1
`define MODE_SYS_ZERO 3'h2
`define MODE_SYS_FULL 3'h3

// ----------------------------------------------------------------
// Serial word lengths and timing
// ----------------------------------------------------------------
`define WORD_LONG 5'h18
`define WORD_SHORT 5'h10
`define CLK_PERIOD_NS 8
`define CAL_PHASE_US 4
`define CAL_PHASE_CYCLES ((`CAL_PHASE_US * 1000) / `CLK_PERIOD_NS)

`endif

// ==== rtl/pin_sync.v ====
`timescale 1ns/100ps

// Two-flop synchroniser; the first stage feeds only the second.
module pin_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire core_clk,
    input wire rstn,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // pin_sync

// ==== rtl/cal_sequencer.v ====
`timescale 1ns/100ps
`include "adc_mode_consts.vh"

// Runs one calibration request: zero-scale and/or full-scale phases.
module cal_sequencer #(
    parameter PHASE_CYCLES = `CAL_PHASE_CYCLES
) (
    input wire core_clk,
    input wire rstn,
    input wire start,
    input wire [2:0] start_mode,
    input wire start_channel,
    output reg busy,
    output reg full_phase,
    output reg cal_channel,
    output reg done
);

    localparam ST_IDLE = 2'h0;
    localparam ST_ZERO = 2'h1;
    localparam ST_FULL = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [15:0] count_q;
    reg two_phase_q;
    wire phase_end;

    assign phase_end = (count_q == PHASE_CYCLES[15:0] - 16'h0001);

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: state_d = ST_IDLE;
            ST_ZERO: if (phase_end) state_d = two_phase_q ? ST_FULL : ST_IDLE;
            ST_FULL: if (phase_end) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
        // A fresh mode write restarts or aborts any sequence in flight
        if (start) begin
            case (start_mode)
                `MODE_SELF_CAL: state_d = ST_ZERO;
                `MODE_SYS_ZERO: state_d = ST_ZERO;
                `MODE_SYS_FULL: state_d = ST_FULL;
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            count_q <= 16'h0000;
            two_phase_q <= 1'b0;
            cal_channel <= 1'b0;
            done <= 1'b0;
        end else begin
            state_q <= state_d;
            done <= 1'b0;
            if (start) begin
                count_q <= 16'h0000;
                two_phase_q <= (start_mode == `MODE_SELF_CAL);
                cal_channel <= start_channel;
            end else if (state_q != ST_IDLE) begin
                count_q <= phase_end ? 16'h0000 : count_q + 16'h0001;
                if (state_d == ST_IDLE)
                    done <= 1'b1;
            end
        end
    end

    always @* begin
        busy = (state_q != ST_IDLE);
        full_phase = (state_q == ST_FULL);
    end

endmodule // cal_sequencer

// ==== rtl/adc_mode_control_register.v ====
`timescale 1ns/100ps
`include "adc_mode_consts.vh"

//Contract
//- Write frame with select low targets the configuration register; host holds select low.
//- Read frame with select low returns the configuration register contents.
//- Register is 24 bits; a write frame shorter than 24 bits is discarded.
//- Clock pulses after the 24th in a write frame are ignored.
//- Lower 12 bits hold the filter field, its top bit at position 11.
//- Mode 000 is normal; select-high read returns result; mode resets to 000.
//- Mode 001 runs self-calibration: zero scale, then full scale, internally.
//- At the end of self-calibration the mode bits clear to 000.
//- Ready falls when self-calibration completes with a valid result.
//- Calibration uses the channel bit present when the mode code is written.
//- Mode 010 runs system zero-scale calibration; ready marks its end.
//- After the zero-scale step the device returns to normal mode.
//- Mode 011 runs system full-scale calibration, flags ready, returns to normal.
//- Ready falls on a new output word, rises after a full word shifts out.
module adc_mode_control_register #(
    parameter CAL_PHASE_CYCLES = `CAL_PHASE_CYCLES
) (
    input wire core_clk,
    input wire rstn,
    input wire serial_clk_in,
    input wire write_frame_sync_n,
    input wire read_frame_sync_n,
    input wire reg_select_in,
    input wire serial_data_io_in,
    output wire serial_data_io_out,
    output wire serial_data_io_oe,
    output wire result_ready_n,
    input wire [23:0] conv_result_in,
    input wire conv_valid_in,
    output wire [2:0] op_mode,
    output wire [2:0] gain_code,
    output wire channel_select,
    output wire power_down_bit,
    output wire word_length_bit,
    output wire excitation_enable,
    output wire burnout_enable,
    output wire polarity_select,
    output wire [11:0] filter_select,
    output wire cal_busy,
    output wire cal_full_phase,
    output wire cal_channel
);

    // ----------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------
    wire [4:0] pins_s;
    wire sclk_s;
    wire wfs_n_s;
    wire rdframe_n_s;
    wire sel_s;
    wire sdi_s;
    reg sclk_prev_q;
    reg wfs_prev_q;
    reg rdframe_prev_q;

    pin_sync #(
        .W(5),
        .RST_VAL(5'h06)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in({serial_data_io_in, reg_select_in, read_frame_sync_n, write_frame_sync_n, serial_clk_in}),
        .sync_out(pins_s)
    );

    assign sclk_s = pins_s[0];
    assign wfs_n_s = pins_s[1];
    assign rdframe_n_s = pins_s[2];
    assign sel_s = pins_s[3];
    assign sdi_s = pins_s[4];

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_prev_q <= 1'b0;
            wfs_prev_q <= 1'b1;
            rdframe_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            wfs_prev_q <= wfs_n_s;
            rdframe_prev_q <= rdframe_n_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire sclk_fall = ~sclk_s & sclk_prev_q;
    wire wfs_start = ~wfs_n_s & wfs_prev_q;
    wire wfs_end = wfs_n_s & ~wfs_prev_q;
    wire rdframe_start = ~rdframe_n_s & rdframe_prev_q;

    // ----------------------------------------------------------------
    // Configuration register and write frame
    // ----------------------------------------------------------------
    reg [23:0] cfg_q;
    reg [23:0] wr_shift_q;
    reg [4:0] wr_count_q;
    reg wr_target_q;
    wire wr_commit;
    wire cal_done;

    // A frame counts only while select stayed low from its first edge on
    assign wr_commit = wfs_end & wr_target_q & (wr_count_q == `WORD_LONG);

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_shift_q <= 24'h000000;
            wr_count_q <= 5'h00;
            wr_target_q <= 1'b0;
        end else begin
            if (wfs_start) begin
                wr_count_q <= 5'h00;
                wr_target_q <= ~sel_s;
            end else if (!wfs_n_s) begin
                if (sel_s)
                    wr_target_q <= 1'b0;
                if (sclk_rise && wr_count_q != `WORD_LONG) begin
                    wr_shift_q <= {wr_shift_q[22:0], sdi_s};
                    wr_count_q <= wr_count_q + 5'h01;
                end
            end
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= `CFG_RESET;
        end else if (wr_commit) begin
            // A host write in the same cycle as completion wins over the self-clear
            cfg_q <= wr_shift_q;
        end else if (cal_done) begin
            cfg_q[`CFG_MODE_HI:`CFG_MODE_LO] <= `MODE_NORMAL;
        end
    end

    assign op_mode = cfg_q[`CFG_MODE_HI:`CFG_MODE_LO];
    assign gain_code = cfg_q[`CFG_GAIN_HI:`CFG_GAIN_LO];
    assign channel_select = cfg_q[`CFG_CHAN];
    assign power_down_bit = cfg_q[`CFG_PDOWN];
    assign word_length_bit = cfg_q[`CFG_WLEN];
    assign excitation_enable = cfg_q[`CFG_EXC];
    assign burnout_enable = cfg_q[`CFG_BURN];
    assign polarity_select = cfg_q[`CFG_POL];
    assign filter_select = cfg_q[`CFG_FILT_HI:`CFG_FILT_LO];

    // ----------------------------------------------------------------
    // Calibration sequencing
    // ----------------------------------------------------------------
    cal_sequencer #(
        .PHASE_CYCLES(CAL_PHASE_CYCLES)
    ) u_cal_sequencer (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(wr_commit),
        .start_mode(wr_shift_q[`CFG_MODE_HI:`CFG_MODE_LO]),
        .start_channel(wr_shift_q[`CFG_CHAN]),
        .busy(cal_busy),
        .full_phase(cal_full_phase),
        .cal_channel(cal_channel),
        .done(cal_done)
    );

    // ----------------------------------------------------------------
    // Result word and ready flag
    // ----------------------------------------------------------------
    reg [23:0] result_q;
    reg ready_n_q;
    reg rd_data_q;
    reg [4:0] rd_count_q;
    wire [4:0] rd_len;
    wire new_word;
    wire rd_word_done;

    // Conversions arriving mid-calibration are not trustworthy, so drop them
    assign new_word = cal_done | (conv_valid_in & ~cal_busy);
    assign rd_len = word_length_bit ? `WORD_LONG : `WORD_SHORT;
    assign rd_word_done = rd_data_q & ~rdframe_n_s & sclk_rise & (rd_count_q == rd_len - 5'h01);

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            result_q <= `RESULT_RESET;
            ready_n_q <= 1'b1;
        end else begin
            if (conv_valid_in && !cal_busy)
                result_q <= conv_result_in;
            if (new_word)
                ready_n_q <= 1'b0;
            else if (rd_word_done)
                ready_n_q <= 1'b1;
        end
    end

    assign result_ready_n = ready_n_q;

    // ----------------------------------------------------------------
    // Read frame
    // ----------------------------------------------------------------
    reg [23:0] rd_shift_q;
    reg rd_active_q;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_shift_q <= 24'h000000;
            rd_count_q <= 5'h00;
            rd_active_q <= 1'b0;
            rd_data_q <= 1'b0;
        end else if (rdframe_start) begin
            rd_count_q <= 5'h00;
            rd_data_q <= sel_s;
            if (!sel_s) begin
                rd_shift_q <= cfg_q;
                rd_active_q <= 1'b1;
            end else begin
                // Short words go out left-aligned, most significant bit first
                rd_shift_q <= word_length_bit ? result_q : {result_q[23:8], 8'h00};
                rd_active_q <= ~ready_n_q;
            end
        end else if (rdframe_n_s) begin
            rd_active_q <= 1'b0;
        end else if (rd_active_q) begin
            if (sclk_fall)
                rd_shift_q <= {rd_shift_q[22:0], 1'b0};
            if (sclk_rise && rd_count_q != `WORD_LONG)
                rd_count_q <= rd_count_q + 5'h01;
        end
    end

    // A write frame owns the line, so the output driver backs off during it
    assign serial_data_io_out = rd_shift_q[23];
    assign serial_data_io_oe = rd_active_q & wfs_n_s;

endmodule // adc_mode_control_register

// ==== verification/adc_mode_props.sv ====
`timescale 1ns/100ps
module adc_mode_props (
    input wire core_clk,
    input wire rstn,
    input wire write_frame_sync_n,
    input wire read_frame_sync_n,
    input wire reg_select_in,
    input wire serial_data_io_oe,
    input wire result_ready_n,
    input wire conv_valid_in,
    input wire [2:0] op_mode,
    input wire channel_select,
    input wire [11:0] filter_select,
    input wire cal_busy,
    input wire cal_full_phase,
    input wire cal_channel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Calibration
    // ----------------------------------------
    busy_mode_a: assert property ($rose(cal_busy) |-> op_mode inside {3'h1, 3'h2, 3'h3})
        else $error("calibration began without a calibration mode");
    cal_chan_a: assert property ($rose(cal_busy) |-> cal_channel == channel_select)
        else $error("calibration channel differs from written channel");
    full_phase_a: assert property (cal_full_phase |-> cal_busy && op_mode != 3'h2)
        else $error("full scale phase outside its modes");
    mode_clear_a: assert property ($fell(cal_busy) |-> ##[0:1] op_mode == 3'h0)
        else $error("mode bits not cleared after calibration");
    cal_ready_a: assert property ($fell(cal_busy) |-> ##[0:1] !result_ready_n)
        else $error("ready not low after calibration");
    // ----------------------------------------
    // Serial port and ready
    // ----------------------------------------
    cfg_load_a: assert property ($changed(filter_select) |-> write_frame_sync_n && !reg_select_in)
        else $error("config changed outside a write");
    oe_write_a: assert property (!write_frame_sync_n [*6] |-> !serial_data_io_oe)
        else $error("data line driven during a write frame");
    ready_rise_a: assert property ($rose(result_ready_n) |-> !read_frame_sync_n && reg_select_in)
        else $error("ready rose without a data read");
    ready_fall_a: assert property ($fell(result_ready_n) |->
        $past(conv_valid_in) || $past(cal_busy) || $past(cal_busy, 2))
        else $error("ready fell without a new word");
    cover property ($fell(cal_busy));
    cover property ($rose(cal_full_phase));
    cover property ($rose(result_ready_n));
endmodule // adc_mode_props

// ==== verification/host_serial_model.sv ====
`timescale 1ns/100ps
// Host side of the serial port; clock stands low between frames
module host_serial_model (
    output reg sclk,
    output reg wfs_n,
    output reg rd_frame_n,
    output reg sel,
    output reg sd_o,
    input wire sd_i
);
    initial begin
        sclk = 0;
        wfs_n = 1;
        rd_frame_n = 1;
        sel = 0;
        sd_o = 0;
    end
    // Select is held for the whole frame and after it
    task wr(input [23:0] d, input integer n, input s);
        integer i;
        begin
            sel = s;
            #40 wfs_n = 0;
            #80;
            for (i = 0; i < n; i = i + 1) begin
                sd_o = (i < 24) ? d[23 - i] : ~sd_o;
                #80 sclk = 1;
                #80 sclk = 0;
            end
            #40 wfs_n = 1;
            sd_o = ~sd_o;
            #400;
        end
    endtask
    task rd(input s, output [23:0] q);
        integer i;
        begin
            sel = s;
            #40 rd_frame_n = 0;
            #80;
            for (i = 0; i < 24; i = i + 1) begin
                sclk = 1;
                q = {q[22:0], sd_i};
                #80 sclk = 0;
                #80;
            end
            rd_frame_n = 1;
            #400;
        end
    endtask
endmodule // host_serial_model

// ==== verification/adc_mode_control_register_tb_top.sv ====
`timescale 1ns/100ps
module adc_mode_control_register_tb_top;
    // ----------------------------------------
    // Wiring
    // ----------------------------------------
    reg core_clk = 0;
    reg rstn = 0;
    reg conv_valid_in = 0;
    reg [23:0] conv_result_in = 24'h000000;
    wire sclk, wfs_n, rd_frame_n, sel, host_d, sd_out, sd_oe, rdy_n, chan, pdown, wlen, exc, burn, pol, busy;
    wire [2:0] op_mode, gain;
    wire [11:0] filt;
    // Outside a write frame a released line shows the inverse of the device bit, so a missing enable shows up
    wire line = sd_oe ? sd_out : (wfs_n ? ~sd_out : host_d);
    wire [23:0] cfg_seen = {op_mode, gain, chan, pdown, wlen, exc, burn, pol, filt};
    integer seed = 32'h2b3a;
    integer failures = 0;
    integer cmp_count = 0;
    integer i;
    integer oe_cycles = 0;
    reg [23:0] d, q, cfg_exp, res;
    adc_mode_control_register #(.CAL_PHASE_CYCLES(8)) u_dut (.core_clk(core_clk), .rstn(rstn),
        .serial_clk_in(sclk), .write_frame_sync_n(wfs_n), .read_frame_sync_n(rd_frame_n), .reg_select_in(sel),
        .serial_data_io_in(line), .serial_data_io_out(sd_out), .serial_data_io_oe(sd_oe),
        .result_ready_n(rdy_n), .conv_result_in(conv_result_in), .conv_valid_in(conv_valid_in),
        .op_mode(op_mode), .gain_code(gain), .channel_select(chan), .power_down_bit(pdown),
        .word_length_bit(wlen), .excitation_enable(exc), .burnout_enable(burn), .polarity_select(pol),
        .filter_select(filt), .cal_busy(busy), .cal_full_phase(), .cal_channel());
    host_serial_model u_host (.sclk(sclk), .wfs_n(wfs_n), .rd_frame_n(rd_frame_n), .sel(sel), .sd_o(host_d),
        .sd_i(line));
    always @(posedge core_clk) begin
        if (sd_oe === 1'b1)
            oe_cycles <= oe_cycles + 1;
    end
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input [63:0] nm, input [23:0] e, input [23:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Filter top bit forced to zero as the host must
    function [23:0] legal(input [23:0] r, input [2:0] m);
        legal = {m, r[20:12], 1'b0, r[10:0]};
    endfunction
    // Data read: a short word comes out as its top 16 bits, then zeros
    function [23:0] rd_word(input [23:0] r, input w);
        rd_word = w ? r : {r[23:8], 8'h00};
    endfunction
    task report_and_stop;
        begin
            $display("checks %0d failures %0d", cmp_count, failures);
            if (failures == 0 && cmp_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rstn = 1;
        repeat (4) @(posedge core_clk);
        #1 chk("reset", 24'h000000, cfg_seen);
        chk("ready", 24'h000001, {23'h0, rdy_n});
        u_host.rd(0, q);
        chk("rdreset", 24'h000000, q);
        for (i = 0; i < 5; i = i + 1) begin
            d = legal($random(seed), (i == 0) ? 3'h0 : 3'h3 + i);
            u_host.wr(d, 24, 0);
            chk("fields", d, cfg_seen);
            u_host.rd(0, q);
            chk("readback", d, q);
            cfg_exp = d;
        end
        $display("test of plain writes ended");
        u_host.wr(legal($random(seed), 3'h1), 20, 0);
        chk("short", cfg_exp, cfg_seen);
        chk("nocal", 24'h000000, {23'h0, busy});
        chk("nocalrdy", 24'h000001, {23'h0, rdy_n});
        d = legal($random(seed), 3'h0);
        u_host.wr(d, 26, 0);
        chk("long", d, cfg_seen);
        $display("test of frame lengths ended");
        for (i = 1; i < 4; i = i + 1) begin
            res = $random(seed);
            @(posedge core_clk);
            #1 conv_result_in = res;
            conv_valid_in = 1;
            @(posedge core_clk);
            #1 conv_valid_in = 0;
            @(posedge core_clk);
            #1 chk("rdyconv", 24'h000000, {23'h0, rdy_n});
            u_host.rd(1, q);
            chk("conv", rd_word(res, d[15]), q);
            chk("rdyread", 24'h000001, {23'h0, rdy_n});
            d = legal($random(seed), i);
            d[15] = (i != 2);
            u_host.wr(d, 24, 0);
            chk("modeclr", {3'h0, d[20:0]}, cfg_seen);
            chk("rdycal", 24'h000000, {23'h0, rdy_n});
            u_host.rd(1, q);
            chk("result", rd_word(res, d[15]), q);
            chk("rdyhigh", 24'h000001, {23'h0, rdy_n});
        end
        $display("test of calibrations ended");
        i = oe_cycles;
        u_host.rd(1, q);
        chk("refused", 24'h000000, oe_cycles - i);
        chk("rdystay", 24'h000001, {23'h0, rdy_n});
        @(posedge core_clk);
        #1 rstn = 0;
        repeat (2) @(posedge core_clk);
        #1 rstn = 1;
        repeat (4) @(posedge core_clk);
        #1 chk("rerst", 24'h000000, cfg_seen);
        u_host.rd(0, q);
        chk("rdrerst", 24'h000000, q);
        $display("test of refused read and mid-run reset ended");
        report_and_stop;
    end
    // Whole run needs about 105 us
    initial begin
        #300000;
        failures = failures + 1;
        report_and_stop;
    end
endmodule // adc_mode_control_register_tb_top
bind adc_mode_control_register adc_mode_props u_props (.core_clk(core_clk), .rstn(rstn),
    .write_frame_sync_n(write_frame_sync_n), .read_frame_sync_n(read_frame_sync_n),
    .reg_select_in(reg_select_in), .serial_data_io_oe(serial_data_io_oe), .result_ready_n(result_ready_n),
    .conv_valid_in(conv_valid_in), .op_mode(op_mode), .channel_select(channel_select),
    .filter_select(filter_select), .cal_busy(cal_busy), .cal_full_phase(cal_full_phase), .cal_channel(cal_channel));
